// ==== core/cgen_map.svh ====
// Notes on behaviour
// (RULE_01) two plls: processor pll for cores and spdif, audio pll for audio clocks
// (RULE_02) audio reference chosen from crystal, external rate input or host word select
// (RULE_03) software keeps spdif clock between 660 and 2480 times its sample rate
// (RULE_04) each major block has its own clock-stop enable bit
// (RULE_05) each host input and output picks full or half sample rate
// (RULE_06) master mode derives 44.1, 48 or 96 kHz from the 41.6 MHz crystal
// (RULE_07) word select slave at 44.1/48/96 kHz gives 22.579/24.576/49.152 MHz
// (RULE_08) external rate input as source limits the sample rate to 48 kHz
// (RULE_09) tuner clocks divided from crystal; tuner clock 100 or 400 kHz
// (RULE_10) crystal divided by four into processor pll, then divide by 2, 4 or 8; divider select 3 also gives divide by 1
// (RULE_11) processor clock is 650000*(212+multiplier)/2^(3-divider select) Hz
// (RULE_12) processor pll runs at 130 MHz after reset without programming
// (RULE_13) audio pll always gives 512 times the master sample rate; with the crystal reference at 44.1 kHz the code gives 22.583 MHz instead
// (RULE_14) crystal reference preset to 22.583, 24.576 or 49.152 MHz
// (RULE_15) external rate input at 256, 384 or 512 times fs; output 512 times fs
// (RULE_16) lost word select or rate input falls back to crystal, same target rate
// (RULE_17) external reference stays within 20 percent of the target sample rate
// (RULE_18) clock stop and reference switching are glitch-free
`ifndef CGEN_MAP_SVH
`define CGEN_MAP_SVH
`define CGEN_OFS_APD        8'h40
`define CGEN_OFS_CLK_EN     8'h50
`define CGEN_OFS_PPLL       8'h60
`define CGEN_OFS_ACTRL      8'h64
`define CGEN_OFS_STAT       8'h68
`define CGEN_RST_APD        24'h000000
`define CGEN_RST_CLK_EN     24'hFFFFFF
`define CGEN_RST_MSEL       8'hBC
`define CGEN_RST_DSPSEL     2'h2
`define CGEN_RST_ACTRL      24'h000000
`define CGEN_PPLL_MSEL_LSB  0
`define CGEN_PPLL_SEL_LSB   8
`define CGEN_AC_REF_LSB     0
`define CGEN_AC_FS_LSB      2
`define CGEN_AC_RATIO_LSB   4
`define CGEN_AC_TFAST_BIT   6
`define CGEN_AC_HIN_LSB     8
`define CGEN_AC_HOUT_LSB    12
`define CGEN_XTAL_HZ        41600000
`define CGEN_PREDIV         4
`define CGEN_PPLL_STEP_HZ   650000
`define CGEN_PPLL_BASE      212
`define CGEN_PPLL_MAXSH     3
`define CGEN_MCLK_MULT      512
`define CGEN_X441_HZ        32'd22583000
`define CGEN_S441_HZ        32'd22579000
`define CGEN_M48_HZ         32'd24576000
`define CGEN_M96_HZ         32'd49152000
`define CGEN_CLK_HZ         20000000
`define CGEN_TUNER_SLOW_HZ  100000
`define CGEN_TUNER_FAST_HZ  400000
`define CGEN_TSLOW_HALF     (`CGEN_CLK_HZ / (2 * `CGEN_TUNER_SLOW_HZ))
`define CGEN_TFAST_HALF     (`CGEN_CLK_HZ / (2 * `CGEN_TUNER_FAST_HZ))
`define CGEN_GATE_TICK_HZ   1000000
`define CGEN_GATE_DIV       (`CGEN_CLK_HZ / `CGEN_GATE_TICK_HZ)
`define CGEN_LOSS_US        100
`define CGEN_LOSS_CYC       (`CGEN_CLK_HZ / 1000000 * `CGEN_LOSS_US)
`define CGEN_GUARD_CYC      16
`endif

// ==== core/cgen_pkg.sv ====
package cgen_pkg;
   typedef enum logic [1:0] {
      CGEN_REF_XTAL = 2'b00,
      CGEN_REF_WS   = 2'b01,
      CGEN_REF_EXT  = 2'b10
   } cgen_ref_e;
   typedef enum logic [1:0] {
      CGEN_FS_441 = 2'b00,
      CGEN_FS_48  = 2'b01,
      CGEN_FS_96  = 2'b10
   } cgen_fs_e;
   typedef enum logic [1:0] {
      CGEN_SW_RUN   = 2'b00,
      CGEN_SW_HOLD  = 2'b01
   } cgen_sw_e;
endpackage : cgen_pkg

// ==== core/cgen_act_if.sv ====
`timescale 1ns/10ps
interface cgen_act_if;
   logic edge_seen;
   logic alive;
   modport mon (output edge_seen, output alive);
   modport use_side (input edge_seen, input alive);
endinterface : cgen_act_if

// ==== core/cgen_activity.sv ====
`timescale 1ns/10ps
`include "cgen_map.svh"
module cgen_activity (
   input  wire logic  clk,
   input  wire logic  rst_n,
   input  wire logic  pin,
   cgen_act_if.mon    act
);
   import cgen_pkg::*;
   logic [2:0]  sync_q;
   logic        lvl_q;
   logic [11:0] cnt_q;
   logic        edge_q;
   logic        alive_q;
   logic        chg;

   always_ff @(posedge clk) begin
      if (!rst_n) sync_q <= 3'h0;
      else        sync_q <= {sync_q[1:0], pin};
   end

   assign chg = (sync_q[1] == sync_q[2]) && (sync_q[2] != lvl_q);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lvl_q  <= 1'b0;
         edge_q <= 1'b0;
      end else begin
         edge_q <= chg;
         if (chg) lvl_q <= sync_q[2];
      end
   end

   // input counted lost after a quiet interval
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q   <= 12'h000;
         alive_q <= 1'b0;
      end else if (chg) begin
         cnt_q   <= 12'h000;
         alive_q <= 1'b1;
      end else if (cnt_q == 12'(`CGEN_LOSS_CYC - 1)) begin
         alive_q <= 1'b0; // see RULE_16
      end else begin
         cnt_q <= cnt_q + 12'h001;
      end
   end

   assign act.edge_seen = edge_q;
   assign act.alive     = alive_q;
endmodule : cgen_activity

// ==== core/cgen_divider.sv ====
`timescale 1ns/10ps
module cgen_divider (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] period_m1,
   output logic            tick_q
);
   logic [7:0] cnt_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q  <= 8'h00;
         tick_q <= 1'b0;
      end else if (cnt_q >= period_m1) begin
         cnt_q  <= 8'h00;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 8'h01;
         tick_q <= 1'b0;
      end
   end
endmodule : cgen_divider

// ==== core/cgen_top.sv ====
`timescale 1ns/10ps
`include "cgen_map.svh"
module cgen_top (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              host_word_select_input,
   input  wire logic              external_rate_input,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [23:0]       reg_wdata,
   output logic [23:0]            reg_rdata_q,
   output logic [31:0]            proc_clk_hz_q,
   output logic [31:0]            audio_mclk_hz_q,
   output logic [9:0]             audio_ref_div_q,
   output cgen_pkg::cgen_ref_e    audio_ref_q,
   output cgen_pkg::cgen_fs_e     audio_fs_q,
   output logic                   audio_clk_run_q,
   output logic [3:0]             host_in_half_q,
   output logic [3:0]             host_out_half_q,
   output logic [23:0]            blk_clk_en_q,
   output logic [23:0]            apd_q,
   output logic                   tuner_clk_q
);
   import cgen_pkg::*;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic [23:0] apd_reg_q;
   logic [23:0] clk_en_reg_q;
   logic [7:0]  msel_q;
   logic [1:0]  dsp_sel_q;
   logic [23:0] actrl_q;
   cgen_sw_e    sw_q;
   logic [4:0]  guard_q;
   cgen_ref_e   want_ref;
   cgen_ref_e   sel_ref;
   cgen_fs_e    sel_fs;
   cgen_fs_e    eff_fs;
   logic [1:0]  ratio;
   logic        fallback;
   logic        gate_tick;
   logic        tuner_tick;
   logic [7:0]  tuner_half_m1;
   logic [31:0] pll_mult;
   logic [31:0] mclk_hz;
   logic [9:0]  ref_div;

   cgen_act_if ws_act ();
   cgen_act_if ext_act ();

   cgen_activity u_ws_mon (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (host_word_select_input),
      .act   (ws_act.mon)
   );

   cgen_activity u_ext_mon (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (external_rate_input),
      .act   (ext_act.mon)
   );

   // register writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         apd_reg_q    <= `CGEN_RST_APD;
         clk_en_reg_q <= `CGEN_RST_CLK_EN;
         msel_q       <= `CGEN_RST_MSEL; // see RULE_12
         dsp_sel_q    <= `CGEN_RST_DSPSEL; // see RULE_12
         actrl_q      <= `CGEN_RST_ACTRL;
      end else if (reg_wr) begin
         if (hit(reg_addr, `CGEN_OFS_APD))    apd_reg_q    <= reg_wdata;
         if (hit(reg_addr, `CGEN_OFS_CLK_EN)) clk_en_reg_q <= reg_wdata; // see RULE_04
         if (hit(reg_addr, `CGEN_OFS_PPLL)) begin
            msel_q    <= reg_wdata[`CGEN_PPLL_MSEL_LSB +: 8];
            dsp_sel_q <= reg_wdata[`CGEN_PPLL_SEL_LSB +: 2];
         end
         if (hit(reg_addr, `CGEN_OFS_ACTRL))  actrl_q      <= reg_wdata;
      end
   end

   // register reads
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata_q <= 24'h000000;
      end else if (reg_rd) begin
         if (hit(reg_addr, `CGEN_OFS_APD))         reg_rdata_q <= apd_reg_q;
         else if (hit(reg_addr, `CGEN_OFS_CLK_EN)) reg_rdata_q <= clk_en_reg_q;
         else if (hit(reg_addr, `CGEN_OFS_PPLL))
            reg_rdata_q <= {14'h0000, dsp_sel_q, msel_q};
         else if (hit(reg_addr, `CGEN_OFS_ACTRL))  reg_rdata_q <= actrl_q;
         else if (hit(reg_addr, `CGEN_OFS_STAT))
            reg_rdata_q <= {18'h00000, sw_q == CGEN_SW_HOLD, fallback,
                            ext_act.alive, ws_act.alive, audio_ref_q};
         else                                      reg_rdata_q <= 24'h000000;
      end
   end

   // processor pll: crystal/4 reference, multiplier, post-divide
   always_comb begin
      pll_mult = (32'(`CGEN_PPLL_BASE) + {24'h000000, msel_q})
                 * 32'(`CGEN_PPLL_STEP_HZ); // see RULE_10
   end

   always_ff @(posedge clk) begin
      if (!rst_n) proc_clk_hz_q <= 32'h00000000;
      else        proc_clk_hz_q <= pll_mult >> (2'(`CGEN_PPLL_MAXSH) - dsp_sel_q); // see RULE_11
   end

   // audio reference request and fallback
   always_comb begin
      sel_ref  = cgen_ref_e'(actrl_q[`CGEN_AC_REF_LSB +: 2]);
      sel_fs   = cgen_fs_e'(actrl_q[`CGEN_AC_FS_LSB +: 2]);
      ratio    = actrl_q[`CGEN_AC_RATIO_LSB +: 2];
      want_ref = CGEN_REF_XTAL; // see RULE_02
      if (sel_ref == CGEN_REF_WS && ws_act.alive)   want_ref = CGEN_REF_WS;
      if (sel_ref == CGEN_REF_EXT && ext_act.alive) want_ref = CGEN_REF_EXT;
      fallback = (sel_ref != CGEN_REF_XTAL) && (want_ref == CGEN_REF_XTAL); // see RULE_16
      eff_fs   = sel_fs;
      if (sel_fs != CGEN_FS_441 && sel_fs != CGEN_FS_48 && sel_fs != CGEN_FS_96)
         eff_fs = CGEN_FS_48;
      if (sel_ref == CGEN_REF_EXT && eff_fs == CGEN_FS_96)
         eff_fs = CGEN_FS_48; // see RULE_08
   end

   // 512 x fs target per active reference
   always_comb begin
      mclk_hz = `CGEN_M48_HZ;
      ref_div = 10'd1;
      unique case (audio_fs_q)
         CGEN_FS_441: mclk_hz = (audio_ref_q == CGEN_REF_XTAL) ?
                                `CGEN_X441_HZ : `CGEN_S441_HZ; // see RULE_14
         CGEN_FS_48:  mclk_hz = `CGEN_M48_HZ; // see RULE_13
         CGEN_FS_96:  mclk_hz = `CGEN_M96_HZ; // see RULE_06
         default:     mclk_hz = `CGEN_M48_HZ;
      endcase
      unique case (audio_ref_q)
         CGEN_REF_XTAL: ref_div = 10'd1;
         CGEN_REF_WS:   ref_div = 10'd1; // see RULE_07
         CGEN_REF_EXT: begin
            if (ratio == 2'h1)      ref_div = 10'd384; // see RULE_15
            else if (ratio == 2'h2) ref_div = 10'd512;
            else                    ref_div = 10'd256;
         end
         default:       ref_div = 10'd1;
      endcase
   end

   // glitch-free reference switch: stop, settle, resume
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sw_q            <= CGEN_SW_RUN;
         guard_q         <= 5'h00;
         audio_ref_q     <= CGEN_REF_XTAL;
         audio_fs_q      <= CGEN_FS_441;
         audio_clk_run_q <= 1'b1;
      end else begin
         unique case (sw_q)
            CGEN_SW_RUN: begin
               if (want_ref != audio_ref_q || eff_fs != audio_fs_q) begin
                  sw_q            <= CGEN_SW_HOLD;
                  guard_q         <= 5'h00;
                  audio_clk_run_q <= 1'b0; // see RULE_18
               end
            end
            CGEN_SW_HOLD: begin
               if (guard_q == 5'(`CGEN_GUARD_CYC - 1)) begin
                  sw_q            <= CGEN_SW_RUN;
                  audio_ref_q     <= want_ref;
                  audio_fs_q      <= eff_fs;
                  audio_clk_run_q <= 1'b1;
               end else begin
                  guard_q <= guard_q + 5'h01;
               end
            end
            default: sw_q <= CGEN_SW_RUN;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         audio_mclk_hz_q <= `CGEN_X441_HZ;
         audio_ref_div_q <= 10'd1;
      end else begin
         audio_mclk_hz_q <= mclk_hz;
         audio_ref_div_q <= ref_div;
      end
   end

   // half-rate selects per host port
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         host_in_half_q  <= 4'h0;
         host_out_half_q <= 4'h0;
      end else begin
         host_in_half_q  <= actrl_q[`CGEN_AC_HIN_LSB +: 4]; // see RULE_05
         host_out_half_q <= actrl_q[`CGEN_AC_HOUT_LSB +: 4]; // see RULE_05
      end
   end

   // block clock stops only change on a slow boundary
   cgen_divider u_gate_div (
      .clk       (clk),
      .rst_n     (rst_n),
      .period_m1 (8'(`CGEN_GATE_DIV - 1)),
      .tick_q    (gate_tick)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blk_clk_en_q <= `CGEN_RST_CLK_EN;
         apd_q        <= `CGEN_RST_APD;
      end else if (gate_tick) begin
         blk_clk_en_q <= clk_en_reg_q; // see RULE_18
         apd_q        <= apd_reg_q;
      end
   end

   // tuner reference clock from crystal division
   assign tuner_half_m1 = actrl_q[`CGEN_AC_TFAST_BIT] ?
                          8'(`CGEN_TFAST_HALF - 1) : 8'(`CGEN_TSLOW_HALF - 1);

   cgen_divider u_tuner_div (
      .clk       (clk),
      .rst_n     (rst_n),
      .period_m1 (tuner_half_m1),
      .tick_q    (tuner_tick)
   );

   always_ff @(posedge clk) begin
      if (!rst_n)          tuner_clk_q <= 1'b0;
      else if (tuner_tick) tuner_clk_q <= ~tuner_clk_q; // see RULE_09
   end

   // both plls are modelled: proc_clk_hz_q and audio_mclk_hz_q // see RULE_01
endmodule : cgen_top

// ==== verification/cgen_host_model.sv ====
`timescale 1ns/10ps
module cgen_host_model #(
   parameter int WS_HALF_NS  = 10417,
   parameter int EXT_HALF_NS = 41
) (
   input  wire logic ws_run,
   input  wire logic ext_run,
   output logic      host_word_select_input,
   output logic      external_rate_input
);
   initial host_word_select_input = 1'b0;
   initial external_rate_input = 1'b0;
   // word select at 48 kHz; a stopped host leaves the line static
   always begin
      #WS_HALF_NS;
      if (ws_run) host_word_select_input = !host_word_select_input;
   end
   // rate input near 256 times 48 kHz
   always begin
      #EXT_HALF_NS;
      if (ext_run) external_rate_input = !external_rate_input;
   end
endmodule : cgen_host_model

// ==== verification/cgen_top_asserts.sv ====
`timescale 1ns/10ps
`include "cgen_map.svh"
module cgen_top_chk (
   input wire logic                clk,
   input wire logic                rst_n,
   input wire logic                host_word_select_input,
   input wire logic                external_rate_input,
   input wire logic                reg_wr,
   input wire logic [7:0]          reg_addr,
   input wire logic [23:0]         reg_wdata,
   input wire logic [31:0]         proc_clk_hz_q,
   input wire logic [31:0]         audio_mclk_hz_q,
   input wire cgen_pkg::cgen_ref_e audio_ref_q,
   input wire cgen_pkg::cgen_fs_e  audio_fs_q,
   input wire logic                audio_clk_run_q,
   input wire logic [3:0]          host_in_half_q,
   input wire logic [3:0]          host_out_half_q,
   input wire logic [23:0]         blk_clk_en_q,
   input wire logic                tuner_clk_q
);
   import cgen_pkg::*;
   logic [23:0] cap_q;
   logic [11:0] ws_quiet_q;
   logic [11:0] ext_quiet_q;
   logic        ws_prev_q;
   logic        ext_prev_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   function automatic logic [31:0] mclk_exp(cgen_ref_e r, cgen_fs_e f);
      if (f == CGEN_FS_96) return `CGEN_M96_HZ;
      if (f == CGEN_FS_48) return `CGEN_M48_HZ;
      return (r == CGEN_REF_XTAL) ? `CGEN_X441_HZ : `CGEN_S441_HZ;
   endfunction : mclk_exp
   // last written data
   always_ff @(posedge clk) begin
      if (reg_wr) cap_q <= reg_wdata;
   end
   // quiet time of each reference pin
   always_ff @(posedge clk) begin
      ws_prev_q  <= host_word_select_input;
      ext_prev_q <= external_rate_input;
      if (!rst_n || host_word_select_input != ws_prev_q) ws_quiet_q <= 12'h000;
      else if (ws_quiet_q != 12'hFFF) ws_quiet_q <= ws_quiet_q + 12'h001;
      if (!rst_n || external_rate_input != ext_prev_q) ext_quiet_q <= 12'h000;
      else if (ext_quiet_q != 12'hFFF) ext_quiet_q <= ext_quiet_q + 12'h001;
   end
   chk_pll_freq_follow: assert property (reg_wr && reg_addr == 8'h60
      |=> ##[0:2] proc_clk_hz_q == (`CGEN_PPLL_STEP_HZ * (`CGEN_PPLL_BASE + cap_q[7:0]))
      >> (`CGEN_PPLL_MAXSH - cap_q[9:8])) else $error("processor clock off formula");
   chk_clk_en_tick: assert property (reg_wr && reg_addr == 8'h50
      |=> ##[0:21] blk_clk_en_q == cap_q) else $error("clock enables not applied");
   chk_half_rate_set: assert property (reg_wr && reg_addr == 8'h64
      |=> ##[0:2] {host_out_half_q, host_in_half_q} == cap_q[15:8])
      else $error("half rate selects not applied");
   chk_guard_low: assert property ($fell(audio_clk_run_q)
      |-> (!audio_clk_run_q) [*8]) else $error("switch guard too short");
   chk_guard_ends: assert property ($fell(audio_clk_run_q)
      |-> ##[1:40] audio_clk_run_q) else $error("switch guard never ends");
   chk_mclk_rate: assert property ($rose(audio_clk_run_q)
      |=> audio_mclk_hz_q == mclk_exp(audio_ref_q, audio_fs_q)) else $error("mclk wrong");
   chk_ext_fs_clamp: assert property (audio_ref_q == CGEN_REF_EXT
      |-> audio_fs_q != CGEN_FS_96) else $error("rate input used above 48 kHz");
   chk_ref_hold: assert property (audio_clk_run_q && $past(audio_clk_run_q)
      |-> $stable(audio_ref_q) && $stable(audio_fs_q)) else $error("ref changed unguarded");
   chk_ws_fallback: assert property (ws_quiet_q == 12'h834
      |-> audio_ref_q != CGEN_REF_WS) else $error("no fallback from word select");
   chk_ext_fallback: assert property (ext_quiet_q == 12'h834
      |-> audio_ref_q != CGEN_REF_EXT) else $error("no fallback from rate input");
   chk_tuner_half: assert property ($rose(tuner_clk_q)
      |-> ##[1:101] $fell(tuner_clk_q)) else $error("tuner clock high too long");
endmodule : cgen_top_chk
bind cgen_top cgen_top_chk i_chk (.clk, .rst_n, .host_word_select_input, .external_rate_input,
   .reg_wr, .reg_addr, .reg_wdata, .proc_clk_hz_q, .audio_mclk_hz_q, .audio_ref_q,
   .audio_fs_q, .audio_clk_run_q, .host_in_half_q, .host_out_half_q, .blk_clk_en_q,
   .tuner_clk_q);

// ==== verification/dsp_and_audio_clock_generation_tb_top.sv ====
`timescale 1ns/10ps
`include "cgen_map.svh"
`define CHK(what, exp, got) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("ERROR %s expected %0h seen %0h", what, (exp), (got)); \
   end \
end
module dsp_and_audio_clock_generation_tb_top;
   import cgen_pkg::*;
   logic        clk;
   logic        rst_n;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_addr;
   logic [23:0] reg_wdata;
   logic        ws_run;
   logic        ext_run;
   logic        host_word_select_input;
   logic        external_rate_input;
   logic [23:0] reg_rdata_q;
   logic [31:0] proc_clk_hz_q;
   logic [31:0] audio_mclk_hz_q;
   logic [9:0]  audio_ref_div_q;
   cgen_ref_e   audio_ref_q;
   cgen_fs_e    audio_fs_q;
   logic        audio_clk_run_q;
   logic [3:0]  host_in_half_q;
   logic [3:0]  host_out_half_q;
   logic [23:0] blk_clk_en_q;
   logic [23:0] apd_q;
   logic        tuner_clk_q;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cycles = 0;
   logic [7:0]  msel [4] = '{8'h00, 8'hD2, 8'hB2, 8'hBC};
   logic [1:0]  dsel [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
   logic [31:0] mx [3] = '{`CGEN_X441_HZ, `CGEN_M48_HZ, `CGEN_M96_HZ};
   cgen_top i_dut (.clk, .rst_n, .host_word_select_input, .external_rate_input, .reg_wr,
      .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .proc_clk_hz_q, .audio_mclk_hz_q,
      .audio_ref_div_q, .audio_ref_q, .audio_fs_q, .audio_clk_run_q, .host_in_half_q,
      .host_out_half_q, .blk_clk_en_q, .apd_q, .tuner_clk_q);
   cgen_host_model i_host (.ws_run, .ext_run, .host_word_select_input, .external_rate_input);
   function automatic logic [31:0] exp_hz(input logic [7:0] m, input logic [1:0] s);
      return (`CGEN_PPLL_STEP_HZ * (`CGEN_PPLL_BASE + m)) >> (`CGEN_PPLL_MAXSH - s);
   endfunction : exp_hz
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [23:0] e);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata_q)
   endtask : rd
   task automatic aset(input logic [23:0] d);
      wr(8'h64, d);
      repeat (24) @(posedge clk);
      #1;
   endtask : aset
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_n
   task automatic tuner_period(input int e);
      time t0;
      repeat (2) @(posedge tuner_clk_q);
      t0 = $time;
      @(posedge tuner_clk_q);
      `CHK("tuner_period", e, int'(($time - t0) / 50))
   endtask : tuner_period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 24'h000000;
      ws_run = 1'b0;
      ext_run = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wait_n(1);
      `CHK("proc_clk_hz", exp_hz(8'hBC, 2'h2), proc_clk_hz_q)
      `CHK("audio_mclk_hz", `CGEN_X441_HZ, audio_mclk_hz_q)
      `CHK("blk_clk_en", 24'hFFFFFF, blk_clk_en_q)
      rd(8'h60, 24'h0002BC);
      rd(8'h50, 24'hFFFFFF);
      rd(8'h44, 24'h000000);
      foreach (msel[i]) begin
         wr(8'h60, {14'h0000, dsel[i], msel[i]});
         rd(8'h60, {14'h0000, dsel[i], msel[i]});
         `CHK("proc_clk_hz", exp_hz(msel[i], dsel[i]), proc_clk_hz_q)
      end
      wr(8'h50, 24'h00F0A5);
      wait_n(22);
      `CHK("blk_clk_en", 24'h00F0A5, blk_clk_en_q)
      wr(8'h40, 24'h000003);
      wait_n(22);
      `CHK("apd", 24'h000003, apd_q)
      for (int f = 0; f < 3; f++) begin
         aset(24'((f << 2) | ((f + 1) << 8) | ((3 - f) << 12)));
         `CHK("audio_fs", cgen_fs_e'(f), audio_fs_q)
         `CHK("audio_mclk_hz", mx[f], audio_mclk_hz_q)
         `CHK("host_in_half", 4'(f + 1), host_in_half_q)
         `CHK("host_out_half", 4'(3 - f), host_out_half_q)
      end
      ws_run <= 1'b1;
      wait_n(500);
      aset(24'h000001);
      `CHK("audio_ref", CGEN_REF_WS, audio_ref_q)
      `CHK("audio_mclk_hz", `CGEN_S441_HZ, audio_mclk_hz_q)
      aset(24'h000009);
      `CHK("audio_mclk_hz", `CGEN_M96_HZ, audio_mclk_hz_q)
      rd(8'h68, 24'h000005);
      ws_run <= 1'b0;
      wait_n(2300);
      `CHK("audio_ref", CGEN_REF_XTAL, audio_ref_q)
      `CHK("audio_mclk_hz", `CGEN_M96_HZ, audio_mclk_hz_q)
      ext_run <= 1'b1;
      wait_n(50);
      for (int r = 0; r < 3; r++) begin
         aset(24'((r << 4) | 8'h0A));
         `CHK("audio_ref", CGEN_REF_EXT, audio_ref_q)
         `CHK("audio_fs", CGEN_FS_48, audio_fs_q)
         `CHK("audio_ref_div", 10'h100 + 10'(r * 128), audio_ref_div_q)
         `CHK("audio_mclk_hz", `CGEN_M48_HZ, audio_mclk_hz_q)
      end
      ext_run <= 1'b0;
      wait_n(2300);
      `CHK("audio_ref", CGEN_REF_XTAL, audio_ref_q)
      `CHK("audio_fs", CGEN_FS_48, audio_fs_q)
      rd(8'h68, 24'h000010);
      tuner_period(`CGEN_CLK_HZ / `CGEN_TUNER_SLOW_HZ);
      wr(8'h64, 24'h000040);
      tuner_period(`CGEN_CLK_HZ / `CGEN_TUNER_FAST_HZ);
      conclude();
   end
endmodule : dsp_and_audio_clock_generation_tb_top
